// ### logic/nsw_timing.sv
// normal space access timing: wishbone wait control register and
// strobe sequencer for one asynchronous chip-select space
// assumes one 10 MHz clock, synchronous inputs, one half bus cycle = 1 clk
//
// Function
// - wait mask clear honours the external wait input, set ignores it.
// - the wait mask acts even with zero access wait cycles programmed.
// - bits 5 to 2 of the wait control register always read as zero.
// - address and chip select stay 0.5 to 3.5 cycles past strobe end.
// - the hold field is bits 1 and 0, read/write, reset to zero.
// - wait codes give 0 to 6, 8, 10, 12, 14, 18 or 24 wait cycles.
// - the strobe follows chip select by 0.5 to 3.5 cycles per setup code.
`timescale 1ns/1ps
`include "nsw_map.svh"
module nsw_timing #(
    parameter int ADDR_W = 24
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              start_i,
    input  wire logic              write_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              ext_wait_n_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic                   chip_select_n_o,
    output logic                   rd_n_o,
    output logic                   we_n_o,
    output logic      [ADDR_W-1:0] addr_o
);
    // ======================================================
    // decoding helpers
    // access wait code to bus cycles, prohibited codes clamp to 24
    function automatic logic [4:0] wait_cycles(input logic [3:0] code);
        logic [4:0] w;
        w = 5'h00;
        if (code <= `NSW_WAIT_LIN_MAX) begin
            w = {1'b0, code};
        end else if (code == 4'h7) begin
            w = `NSW_WAIT_CYC_7;
        end else if (code == 4'h8) begin
            w = `NSW_WAIT_CYC_8;
        end else if (code == 4'h9) begin
            w = `NSW_WAIT_CYC_9;
        end else if (code == 4'hA) begin
            w = `NSW_WAIT_CYC_A;
        end else if (code == 4'hB) begin
            w = `NSW_WAIT_CYC_B;
        end else begin
            w = `NSW_WAIT_CYC_MAX;
        end
        return w;
    endfunction

    // two-bit half-cycle code: 0.5 + code cycles, in half cycles
    function automatic logic [6:0] half_clks(input logic [1:0] code);
        return {4'h0, code, 1'b1};
    endfunction

    localparam logic [31:0] CTRL_WMASK = `NSW_CTRL_WMASK;

    logic [31:0]         ctrl_reg;
    logic                ack_reg;
    logic [31:0]         rdat_reg;
    nsw_pkg::nsw_state_t state_reg;
    logic [6:0]          cnt_reg;
    logic                stretch_reg;
    logic                done_reg;
    logic                cs_n_reg;
    logic                rd_n_reg;
    logic                we_n_reg;
    logic                busy_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic                bus_req;
    logic                wait_act;
    logic [6:0]          setup_clks;
    logic [6:0]          hold_clks;
    logic [6:0]          strobe_clks;

    assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wait_act   = ~ctrl_reg[`NSW_MASK_BIT] & ~ext_wait_n_i;
    assign setup_clks = half_clks(ctrl_reg[`NSW_SETUP_HI:`NSW_SETUP_LO]);
    assign hold_clks  = half_clks(ctrl_reg[`NSW_HOLD_HI:`NSW_HOLD_LO]);
    // one bus cycle of strobe plus the access waits
    assign strobe_clks = {1'b0, wait_cycles(
        ctrl_reg[`NSW_WAIT_HI:`NSW_WAIT_LO]), 1'b0} + 7'h02;

    // ======================================================
    // wishbone slave: one-cycle registered ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // wait control register, byte lanes 0 and 1, written at the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `NSW_CTRL_RESET;
        end else if (wb_cyc_i && wb_stb_i && ack_reg && wb_we_i
                     && wb_adr_i == `NSW_OFF_WAIT_CTRL) begin
            if (wb_sel_i[0]) begin
                ctrl_reg[7:0] <= wb_dat_i[7:0] & CTRL_WMASK[7:0];
            end
            if (wb_sel_i[1]) begin
                ctrl_reg[15:8] <= wb_dat_i[15:8] & CTRL_WMASK[15:8];
            end
        end
    end

    // read data, unmapped offsets answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h0000_0000;
        end else if (bus_req && wb_adr_i == `NSW_OFF_WAIT_CTRL) begin
            rdat_reg <= ctrl_reg & `NSW_CTRL_WMASK;
        end else if (bus_req && wb_adr_i == `NSW_OFF_STATUS) begin
            rdat_reg <= {30'h0, stretch_reg,
                         state_reg != nsw_pkg::NSW_IDLE};
        end else begin
            rdat_reg <= 32'h0000_0000;
        end
    end

    // ======================================================
    // access sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= nsw_pkg::NSW_IDLE;
            cnt_reg     <= 7'h00;
            stretch_reg <= 1'b0;
            done_reg    <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                nsw_pkg::NSW_IDLE: begin
                    if (start_i) begin
                        state_reg <= nsw_pkg::NSW_SETUP;
                        cnt_reg   <= setup_clks - 7'h01;
                    end
                end
                nsw_pkg::NSW_SETUP: begin
                    if (cnt_reg == 7'h00) begin
                        state_reg <= nsw_pkg::NSW_STROBE;
                        cnt_reg   <= strobe_clks - 7'h01;
                    end else begin
                        cnt_reg <= cnt_reg - 7'h01;
                    end
                end
                nsw_pkg::NSW_STROBE: begin
                    if (cnt_reg != 7'h00) begin
                        cnt_reg <= cnt_reg - 7'h01;
                    end else if (wait_act) begin
                        stretch_reg <= 1'b1;
                    end else begin
                        stretch_reg <= 1'b0;
                        state_reg   <= nsw_pkg::NSW_HOLD;
                        cnt_reg     <= hold_clks - 7'h01;
                    end
                end
                default: begin
                    if (cnt_reg == 7'h00) begin
                        state_reg <= nsw_pkg::NSW_IDLE;
                        done_reg  <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 7'h01;
                    end
                end
            endcase
        end
    end

    // chip select, busy and address launch on the accepting edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            addr_reg <= '0;
        end else if (state_reg == nsw_pkg::NSW_IDLE && start_i) begin
            cs_n_reg <= 1'b0;
            busy_reg <= 1'b1;
            addr_reg <= addr_i;
        end else if (state_reg == nsw_pkg::NSW_HOLD && cnt_reg == 7'h00) begin
            cs_n_reg <= 1'b1;
            busy_reg <= 1'b0;
        end
    end

    logic dir_write_reg;
    // direction latch and strobe drive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_write_reg <= 1'b0;
        end else if (state_reg == nsw_pkg::NSW_IDLE && start_i) begin
            dir_write_reg <= write_i;
        end
    end

    // strobe pins are flops of their own so no gate sits on the pin path
    logic strobe_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_reg <= 1'b0;
            rd_n_reg   <= 1'b1;
            we_n_reg   <= 1'b1;
        end else if (state_reg == nsw_pkg::NSW_SETUP && cnt_reg == 7'h00) begin
            strobe_reg <= 1'b1;
            rd_n_reg   <= dir_write_reg;
            we_n_reg   <= ~dir_write_reg;
        end else if (state_reg == nsw_pkg::NSW_STROBE && cnt_reg == 7'h00
                     && !wait_act) begin
            strobe_reg <= 1'b0;
            rd_n_reg   <= 1'b1;
            we_n_reg   <= 1'b1;
        end
    end

    assign wb_ack_o        = ack_reg;
    assign wb_dat_o        = rdat_reg;
    assign busy_o          = busy_reg;
    assign done_o          = done_reg;
    assign chip_select_n_o = cs_n_reg;
    assign rd_n_o          = rd_n_reg;
    assign we_n_o          = we_n_reg;
    assign addr_o          = addr_reg;

    // ======================================================
    // checks
    default clocking nsw_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // clocks spent in the current state; it shows the full count one
    // edge after the last clock of that state
    logic [6:0] phase_len;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_len <= 7'h00;
        end else if (state_reg != $past(state_reg)) begin
            phase_len <= 7'h01;
        end else if (phase_len != 7'h7F) begin
            phase_len <= phase_len + 7'h01;
        end
    end

    a_mask_ignores_wait: assert property (
        state_reg == nsw_pkg::NSW_STROBE && cnt_reg == 7'h00
        && ctrl_reg[`NSW_MASK_BIT] |=> state_reg == nsw_pkg::NSW_HOLD)
        else $error("mask set but access stretched");
    a_zero_wait_stretch: assert property (
        state_reg == nsw_pkg::NSW_STROBE && cnt_reg == 7'h00
        && ctrl_reg[`NSW_WAIT_HI:`NSW_WAIT_LO] == 4'h0
        && !ctrl_reg[`NSW_MASK_BIT] && !ext_wait_n_i
        |=> state_reg == nsw_pkg::NSW_STROBE)
        else $error("zero waits ignored external wait");
    a_reserved_zero: assert property (
        $rose(ack_reg) && $past(wb_adr_i) == `NSW_OFF_WAIT_CTRL
        |-> rdat_reg[5:2] == 4'h0 && rdat_reg[31:13] == 19'h0)
        else $error("reserved bits read nonzero");
    a_hold_length: assert property (
        state_reg == nsw_pkg::NSW_HOLD && cnt_reg == 7'h00
        |=> phase_len == hold_clks && cs_n_reg && !strobe_reg)
        else $error("hold time wrong");
    a_hold_reset: assert property (
        $fell(rst_i) |-> ctrl_reg[`NSW_HOLD_HI:`NSW_HOLD_LO] == 2'h0)
        else $error("hold field not reset to zero");
    a_strobe_length: assert property (
        state_reg == nsw_pkg::NSW_STROBE && cnt_reg == 7'h00
        && ctrl_reg[`NSW_MASK_BIT] |=> phase_len == strobe_clks)
        else $error("access wait length wrong");
    a_setup_length: assert property (
        $rose(strobe_reg) |-> !cs_n_reg && phase_len == setup_clks)
        else $error("setup time wrong");
    a_wait_holds_strobe: assert property (
        state_reg == nsw_pkg::NSW_STROBE && cnt_reg == 7'h00 && wait_act
        |=> strobe_reg ##1 (strobe_reg || state_reg == nsw_pkg::NSW_HOLD))
        else $error("strobe released during external wait");

    c_read_access: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(rd_n_reg) ##[1:80] done_reg);
    c_write_access: cover property (@(posedge clk_i) disable iff (rst_i)
        !we_n_o ##[1:80] done_reg);
    c_stretched: cover property (@(posedge clk_i) disable iff (rst_i)
        stretch_reg ##[1:80] done_reg);
endmodule

// ### shared/nsw_map.svh
// register map, field positions, reset values and timing codes of the
// normal space wait timing block; definitions only
`ifndef NSW_MAP_SVH
`define NSW_MAP_SVH

// ==========================================================
// register byte offsets
`define NSW_OFF_WAIT_CTRL   4'h0
`define NSW_OFF_STATUS      4'h4

// ==========================================================
// wait control fields
`define NSW_SETUP_HI        12
`define NSW_SETUP_LO        11
`define NSW_WAIT_HI         10
`define NSW_WAIT_LO         7
`define NSW_MASK_BIT        6
`define NSW_HOLD_HI         1
`define NSW_HOLD_LO         0
`define NSW_CTRL_WMASK      32'h0000_1FC3
`define NSW_CTRL_RESET      32'h0000_0500

// ==========================================================
// access wait codes: linear up to code 6, then stepped counts
`define NSW_WAIT_LIN_MAX    4'h6
`define NSW_WAIT_CYC_7      5'h08
`define NSW_WAIT_CYC_8      5'h0A
`define NSW_WAIT_CYC_9      5'h0C
`define NSW_WAIT_CYC_A      5'h0E
`define NSW_WAIT_CYC_B      5'h12
`define NSW_WAIT_CYC_MAX    5'h18

// ==========================================================
// status fields
`define NSW_STAT_BUSY       0
`define NSW_STAT_STRETCH    1
`endif

// ### shared/nsw_pkg.sv
// types of the normal space wait timing block
// assumes nsw_map.svh supplies the numeric constants
package nsw_pkg;
    // ======================================================
    // access sequencer states
    typedef enum logic [2:0] {
        NSW_IDLE,
        NSW_SETUP,
        NSW_STROBE,
        NSW_HOLD
    } nsw_state_t;
endpackage

// ### testbench/nsw_ext_mem.sv
// external device model: drives the wait line of one chip-select space
// assumes active low strobes and a stall count set by the bench
`timescale 1ns/1ps
module nsw_ext_mem (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       rd_n_i,
    input  wire logic       we_n_i,
    input  wire logic [7:0] stall_i,
    output logic            ext_wait_n_o
);
    logic [7:0] cnt_reg;
    // ======================================================
    // wait held active from the second strobe clock through strobe clock stall_i
    always_ff @(posedge clk_i) begin
        if (rst_i || (rd_n_i && we_n_i)) begin
            cnt_reg      <= 8'h00;
            ext_wait_n_o <= 1'b1; // pulled-up idle level
        end else begin
            cnt_reg      <= cnt_reg + 8'h01;
            ext_wait_n_o <= (cnt_reg + 8'h01 >= stall_i);
        end
    end
endmodule

// ### testbench/tb_top.sv
// self-checking bench of the normal space wait timing block
// assumes a 10 MHz clock and a wishbone master in this module
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic        wr;
        logic [7:0]  s, w, h;
        logic [23:0] adr;
    } nsw_exp_t;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, start_i, write_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, ext_wait_n_i, busy_o, done_o;
    logic        chip_select_n_o, rd_n_o, we_n_o, stb_n;
    logic [23:0] addr_i, addr_o;
    logic [7:0]  stall;
    nsw_exp_t    eq[$];
    logic [31:0] rq[$];
    int          err_total, checked, now, t_cs, t_sf, t_sr, t_cr;
    logic        prev_cs, prev_st, seen_wr, seen_busy;
    logic [23:0] seen_adr;
    int          waits [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
    assign stb_n = rd_n_o & we_n_o;
    // ======================================================
    // design and far-side model
    nsw_timing DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .start_i(start_i), .write_i(write_i),
        .addr_i(addr_i), .ext_wait_n_i(ext_wait_n_i), .busy_o(busy_o),
        .done_o(done_o), .chip_select_n_o(chip_select_n_o),
        .rd_n_o(rd_n_o), .we_n_o(we_n_o), .addr_o(addr_o));
    nsw_ext_mem u_mem (.clk_i(clk_i), .rst_i(rst_i), .rd_n_i(rd_n_o),
        .we_n_i(we_n_o), .stall_i(stall), .ext_wait_n_o(ext_wait_n_i));
    // ======================================================
    // clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #2000000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        end_sim;
    end
    // ======================================================
    // comparison and closing
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ======================================================
    // wishbone single cycle, released at the ack edge
    task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    // one access: program timing, note expectation, start twice
    task acc(input logic [1:0] su, input logic [3:0] code, input logic msk,
             input logic [1:0] hd, input logic [7:0] st);
        nsw_exp_t e;
        e.wr  = 1'($urandom);
        e.adr = 24'($urandom);
        e.s   = 8'(2 * su + 1);
        e.h   = 8'(2 * hd + 1);
        e.w   = 8'(2 * (waits[code] + 1));
        if (!msk && st + 8'h01 > e.w) e.w = st + 8'h01;
        wb(1'b1, 4'h0, {19'h0, su, code, msk, 4'h0, hd});
        stall <= st;
        eq.push_back(e);
        @(posedge clk_i);
        start_i <= 1'b1;
        write_i <= e.wr;
        addr_i  <= e.adr;
        repeat (2) @(posedge clk_i); // second start edge falls while busy
        start_i <= 1'b0;
        while (eq.size() != 0) @(posedge clk_i);
    endtask
    // ======================================================
    // output watcher: edge times of chip select and strobe
    always @(posedge clk_i) begin
        nsw_exp_t e;
        now++;
        if (prev_cs && !chip_select_n_o) t_cs = now;
        if (prev_st && !stb_n) begin
            t_sf = now;
            seen_wr = !we_n_o;
            seen_adr = addr_o;
            seen_busy = busy_o;
        end
        if (!prev_st && stb_n) t_sr = now;
        if (!prev_cs && chip_select_n_o) t_cr = now;
        prev_cs = chip_select_n_o;
        prev_st = stb_n;
        if (wb_ack_o === 1'b1 && !wb_we_i)
            chk(wb_dat_o, rq.pop_front());
        if (done_o === 1'b1) begin
            e = eq.pop_front();
            chk(32'(seen_wr), 32'(e.wr));
            chk(32'(seen_adr), 32'(e.adr));
            chk(t_sf - t_cs, 32'(e.s));
            chk(t_sr - t_sf, 32'(e.w));
            chk(t_cr - t_sr, 32'(e.h));
            chk(32'(seen_busy), 32'h1);
            chk(32'(busy_o), 32'h0);
        end
    end
    // ======================================================
    // main sequence
    initial begin
        {rst_i, prev_cs, prev_st} = 3'h7;
        {wb_cyc_i, wb_stb_i, wb_we_i, start_i, write_i} = 5'h00;
        {wb_adr_i, wb_dat_i, addr_i, stall} = 68'h0;
        wb_sel_i = 4'hF;
        void'($urandom(46));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rq.push_back(32'h0000_0500);
        wb(1'b0, 4'h0, 32'h0);
        rq.push_back(32'h0000_0000);
        wb(1'b0, 4'h8, 32'h0);
        rq.push_back(32'h0000_0000);
        wb(1'b0, 4'h4, 32'h0);
        $display("test reset_values done");
        wb(1'b1, 4'h0, 32'hFFFF_FFFF);
        rq.push_back(32'h0000_1FC3);
        wb(1'b0, 4'h0, 32'h0);
        $display("test reserved_bits done");
        for (int c = 0; c < 13; c++)
            acc(2'($urandom), 4'(c), 1'b1, 2'($urandom),
                8'($urandom % 30));
        $display("test wait_codes done");
        acc(2'h0, 4'h0, 1'b0, 2'h0, 8'h06);
        acc(2'h0, 4'h0, 1'b1, 2'h3, 8'h06);
        acc(2'h3, 4'h2, 1'b0, 2'h1, 8'h0A);
        $display("test ext_wait done");
        end_sim;
    end
endmodule
